// ### verilog/irq_mode_cfg.svh
`ifndef IRQ_MODE_CFG_SVH
`define IRQ_MODE_CFG_SVH

// register addresses on the plain register port
`define MODE_CTRL_B_ADDR   32'hFFFF_E018
`define IRQ_STATUS_ADDR    32'hFFFF_E100
`define IRQ_MASK_ADDR      32'hFFFF_E104

// field layout inside one byte-wide source group
`define GRP_VALUE_LSB      0
`define GRP_DMA_BIT        4
`define GRP_ACT_LSB        5

// writable bits of the mode register: three groups, bits 3 and 7 of each
// group and the whole low byte stay zero
`define MODE_WRITE_MASK    32'h7777_7700
`define MODE_RESET         32'h0000_0000

// active-state code that enables rising-edge detection
`define ACT_RISING         2'h3
// level code that keeps a source away from the core
`define LEVEL_DISABLED     3'h0
// interrupt number of the first source handled here
`define FIRST_SRC_NUM      5'h19

`endif

// ### verilog/irq_mode_pkg.sv
package irq_mode_pkg;

  // a priority level or a dma channel number
  typedef logic [2:0] level_t;

  // where a detected request goes
  typedef enum logic [1:0] {ROUTE_NONE, ROUTE_CPU, ROUTE_DMA} route_t;

endpackage : irq_mode_pkg

// ### verilog/src_channel.sv
`timescale 1ns/1ns
`include "irq_mode_cfg.svh"

module src_channel
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  request_in,
  input  wire logic [7:0]            group_in,
  output logic                       edge_out,
  output irq_mode_pkg::route_t       route_out,
  output irq_mode_pkg::level_t       value_out
);
  import irq_mode_pkg::*;

  logic prev_q;
  wire  active_rising;
  wire  dma_sel;

  // request history for edge detection
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      prev_q <= 1'b0;
    else
      prev_q <= request_in;
  end

  // only the rising-edge setting detects anything
  assign active_rising = group_in[`GRP_ACT_LSB +: 2] == `ACT_RISING;
  assign edge_out      = request_in & ~prev_q & active_rising;
  assign dma_sel       = group_in[`GRP_DMA_BIT];
  assign value_out     = group_in[`GRP_VALUE_LSB +: 3];

  // dma trigger or core interrupt; level zero goes nowhere unless the dma bit is set
  always_comb
  begin
    if (!edge_out)
      route_out = ROUTE_NONE;
    else if (dma_sel)
      route_out = ROUTE_DMA;
    else if (value_out == `LEVEL_DISABLED)
      route_out = ROUTE_NONE;
    else
      route_out = ROUTE_CPU;
  end

endmodule : src_channel

// ### verilog/source_pick.sv
`timescale 1ns/1ns

module source_pick
(
  input  wire logic [2:0]            eligible_in,
  input  wire logic [8:0]            levels_in,
  output logic                       any_out,
  output irq_mode_pkg::level_t       level_out,
  output logic [1:0]                 index_out
);
  import irq_mode_pkg::*;

  // highest level wins, equal levels go to the lower interrupt number
  always_comb
  begin
    any_out   = 1'b0;
    level_out = 3'h0;
    index_out = 2'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (eligible_in[i] && (!any_out || levels_in[3*i +: 3] > level_out))
      begin
        any_out   = 1'b1;
        level_out = levels_in[3*i +: 3];
        index_out = 2'(i);
      end
    end
  end

endmodule : source_pick

// ### verilog/timer_irq_mode_control_slice.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "irq_mode_cfg.svh"

module timer_irq_mode_control_slice
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_in,
  input  wire logic [31:0]           reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  output logic      [31:0]           reg_rdata_out,
  input  wire logic                  timer_ch2_request_in,
  input  wire logic                  timer_ch3_request_in,
  input  wire logic                  timer_ch4_request_in,
  input  wire logic                  cpu_ack_in,
  output logic                       cpu_irq_out,
  output irq_mode_pkg::level_t       cpu_level_out,
  output logic      [4:0]            cpu_irq_num_out,
  output logic      [7:0]            dma_req_out,
  output logic                       irq_out
);
  import irq_mode_pkg::*;

  localparam int NSRC = 3;

  logic [31:0] mode_q;
  logic [2:0]  status_q;
  logic [2:0]  status_d;
  logic [2:0]  mask_q;
  logic [2:0]  pend_q;
  logic [2:0]  pend_d;
  logic [2:0]  pend_set;
  logic [7:0]  dma_q;
  logic [7:0]  dma_d;
  logic        cpu_irq_q;
  level_t      cpu_level_q;
  logic [1:0]  cpu_idx_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  wire [NSRC-1:0] req_vec;
  wire [NSRC-1:0] src_edge;
  route_t         src_route [NSRC];
  level_t         src_value [NSRC];
  wire [NSRC-1:0] eligible;
  wire [8:0]      levels;
  wire [2:0]      pend_clr;
  wire            pick_any;
  level_t         pick_level;
  wire [1:0]      pick_idx;

  // address decode
  wire sel_mode   = reg_addr_in == `MODE_CTRL_B_ADDR;
  wire sel_status = reg_addr_in == `IRQ_STATUS_ADDR;
  wire sel_mask   = reg_addr_in == `IRQ_MASK_ADDR;
  wire wr_mode    = reg_write_in & sel_mode;
  wire wr_mask    = reg_write_in & sel_mask;
  wire rd_status  = reg_read_in & sel_status;

  // timer channel 2, 3, 4 feed interrupt numbers 25, 26, 27
  assign req_vec = {timer_ch4_request_in, timer_ch3_request_in,
                    timer_ch2_request_in};

  // one detector per source on its own byte group of the mode register
  generate
    for (genvar g = 0; g < NSRC; g++)
    begin : g_src
      src_channel u_src
      (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .request_in (req_vec[g]),
        .group_in   (mode_q[8*(g+1) +: 8]),
        .edge_out   (src_edge[g]),
        .route_out  (src_route[g]),
        .value_out  (src_value[g])
      );
    end
  endgenerate

  // mode register: only the field bits take write data
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      mode_q <= `MODE_RESET;
    else if (wr_mode)
      mode_q <= reg_wdata_in & `MODE_WRITE_MASK;
  end

  // core-bound sets and dma channel pulses from this cycle's edges
  always_comb
  begin
    pend_set = 3'h0;
    dma_d    = 8'h00;
    for (int i = 0; i < NSRC; i++)
    begin
      if (src_route[i] == ROUTE_CPU)
        pend_set[i] = 1'b1;
      if (src_route[i] == ROUTE_DMA)
        dma_d[src_value[i]] = 1'b1;
    end
  end

  // a source may reach the core only while set up for a nonzero level
  assign eligible = {mode_q[28] == 1'b0 && mode_q[26:24] != `LEVEL_DISABLED,
                     mode_q[20] == 1'b0 && mode_q[18:16] != `LEVEL_DISABLED,
                     mode_q[12] == 1'b0 && mode_q[10:8] != `LEVEL_DISABLED};
  assign levels   = {mode_q[26:24], mode_q[18:16], mode_q[10:8]};

  // the core's acknowledge retires the presented source; a new edge wins
  assign pend_clr = (cpu_ack_in && cpu_irq_q) ? 3'(1 << cpu_idx_q) : 3'h0;
  assign pend_d   = (pend_q & ~pend_clr) | pend_set;

  source_pick u_pick
  (
    .eligible_in (pend_d & eligible),
    .levels_in   (levels),
    .any_out     (pick_any),
    .level_out   (pick_level),
    .index_out   (pick_idx)
  );

  // pending flags and the request presented to the core
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pend_q      <= 3'h0;
      cpu_irq_q   <= 1'b0;
      cpu_level_q <= 3'h0;
      cpu_idx_q   <= 2'h0;
    end
    else
    begin
      pend_q      <= pend_d;
      cpu_irq_q   <= pick_any;
      cpu_level_q <= pick_level;
      cpu_idx_q   <= pick_idx;
    end
  end

  // dma trigger pulses, one cycle per detected edge
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      dma_q <= 8'h00;
    else
      dma_q <= dma_d;
  end

  // sticky edge status, cleared by reading it; an edge beats the clear
  assign status_d = (status_q & ~{3{rd_status}}) | src_edge;

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      status_q <= 3'h0;
      mask_q   <= 3'h0;
    end
    else
    begin
      status_q <= status_d;
      if (wr_mask)
        mask_q <= reg_wdata_in[2:0];
    end
  end

  // read data selection; unmapped addresses read zero
  assign rd_mux = sel_mode   ? mode_q                  :
                  sel_status ? {29'h0, status_q}       :
                  sel_mask   ? {29'h0, mask_q}         : 32'h0000_0000;

  // read data stand for the single cycle after the read strobe
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_q <= 32'h0000_0000;
    else if (reg_read_in)
      rdata_q <= rd_mux;
    else
      rdata_q <= 32'h0000_0000;
  end

  // outputs
  assign reg_rdata_out   = rdata_q;
  assign dma_req_out     = dma_q;
  assign cpu_irq_out     = cpu_irq_q;
  assign cpu_level_out   = cpu_level_q;
  assign cpu_irq_num_out = `FIRST_SRC_NUM + 5'(cpu_idx_q);
  assign irq_out         = |(status_q & mask_q);

  // a dma-routed edge of number 26 pulses the selected channel
  property p_dma_route;
    @(posedge sys_clk_in) disable iff (reset_in)
    src_edge[1] && mode_q[20] |=> dma_req_out[$past(mode_q[18:16])];
  endproperty
  a_dma_route: assert property (p_dma_route)
    else $error("dma trigger missing on selected channel");

  // a dma-routed edge never reaches the core
  property p_dma_no_cpu;
    @(posedge sys_clk_in) disable iff (reset_in)
    !pend_q[1] && src_edge[1] && mode_q[20] |=> !pend_q[1];
  endproperty
  a_dma_no_cpu: assert property (p_dma_no_cpu)
    else $error("dma trigger raised a core request");

  // level zero keeps the source off the core; only this source has an edge
  property p_level_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
    !pend_q[1] && src_edge == 3'h2 && !mode_q[20] && mode_q[18:16] == 3'h0
      |=> !pend_q[1] && dma_req_out == 8'h00;
  endproperty
  a_level_zero: assert property (p_level_zero)
    else $error("disabled level still requested");

  // a nonzero level raises the core request the next cycle
  property p_level_set;
    @(posedge sys_clk_in) disable iff (reset_in)
    src_edge[2] && !mode_q[28] && mode_q[26:24] != 3'h0
      |=> pend_q[2] && cpu_irq_out;
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("core request missing after edge");

  // the level shown to the core is never the disabled code
  property p_level_nonzero;
    @(posedge sys_clk_in) disable iff (reset_in)
    cpu_irq_out |-> cpu_level_out != 3'h0 && cpu_irq_num_out >= 5'h19;
  endproperty
  a_level_nonzero: assert property (p_level_nonzero)
    else $error("core request with level zero");

  // timer channel 3 lands in the status bit of number 26
  property p_ch3_map;
    @(posedge sys_clk_in) disable iff (reset_in)
    $rose(timer_ch3_request_in) && mode_q[22:21] == 2'h3 |=> status_q[1];
  endproperty
  a_ch3_map: assert property (p_ch3_map)
    else $error("channel 3 edge not recorded for number 26");

  // reserved bits of the mode register read zero
  property p_reserved;
    @(posedge sys_clk_in) disable iff (reset_in)
    reg_read_in && reg_addr_in == 32'hFFFF_E018
      |=> (reg_rdata_out & 32'h8888_88FF) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode bit read nonzero");

  // the core's acknowledge retires the shown source when no new edge comes
  property p_ack_retire;
    @(posedge sys_clk_in) disable iff (reset_in)
    cpu_irq_out && cpu_ack_in && cpu_idx_q == 2'h1 && !src_edge[1]
      |=> !pend_q[1];
  endproperty
  a_ack_retire: assert property (p_ack_retire)
    else $error("acknowledged source still pending");

  // a dma trigger only follows an edge of a dma-routed source
  property p_dma_quiet;
    @(posedge sys_clk_in) disable iff (reset_in)
    |dma_req_out |-> $past(|(src_edge & {mode_q[28], mode_q[20], mode_q[12]}));
  endproperty
  a_dma_quiet: assert property (p_dma_quiet)
    else $error("dma trigger without a dma-routed edge");

  // timer channel 4 lands in the status bit of number 27
  property p_ch4_map;
    @(posedge sys_clk_in) disable iff (reset_in)
    $rose(timer_ch4_request_in) && mode_q[30:29] == 2'h3 |=> status_q[2];
  endproperty
  a_ch4_map: assert property (p_ch4_map)
    else $error("channel 4 edge not recorded for number 27");

  // main scenarios
  property p_cov_dma;
    @(posedge sys_clk_in) disable iff (reset_in) |dma_req_out;
  endproperty
  c_cov_dma: cover property (p_cov_dma);

  property p_cov_ack;
    @(posedge sys_clk_in) disable iff (reset_in) cpu_irq_out && cpu_ack_in;
  endproperty
  c_cov_ack: cover property (p_cov_ack);

  property p_cov_irq;
    @(posedge sys_clk_in) disable iff (reset_in) irq_out ##1 rd_status;
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_level_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
    src_edge[1] && !mode_q[20] && mode_q[18:16] == 3'h0;
  endproperty
  c_cov_level_zero: cover property (p_cov_level_zero);

endmodule : timer_irq_mode_control_slice

// ### sim/timer_core_model.sv
`timescale 1ns/1ns

module timer_core_model
#(
  parameter int ACK_WAIT = 3
)
(
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] fire_in,
  input  wire logic       ack_en_in,
  input  wire logic       cpu_irq_in,
  output logic      [2:0] req_out,
  output logic            ack_out
);
  int wait_q;

  // timer requests follow fire pulses; the bench always leaves a low cycle
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      req_out <= 3'h0;
    else
      req_out <= fire_in;
  end

  // core answers a shown request after a few cycles, one-cycle ack pulse
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wait_q  <= 0;
      ack_out <= 1'b0;
    end
    else if (ack_out)
    begin
      ack_out <= 1'b0;
      wait_q  <= 0;
    end
    else if (cpu_irq_in && ack_en_in)
    begin
      ack_out <= (wait_q == ACK_WAIT);
      wait_q  <= wait_q + 1;
    end
  end
endmodule : timer_core_model

// ### sim/tb.sv
`timescale 1ns/1ns
`include "irq_mode_cfg.svh"

module tb;
  import irq_mode_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic [31:0] addr       = 32'h0000_0000;
  logic [31:0] wdata      = 32'h0000_0000;
  logic        write      = 1'b0;
  logic        read       = 1'b0;
  logic [2:0]  fire       = 3'h0;
  logic        ack_en     = 1'b0;
  logic [31:0] rdata;
  logic [2:0]  req;
  logic        ack;
  logic        cpu_irq;
  level_t      lvl;
  logic [4:0]  num;
  logic [7:0]  dma;
  logic        irq;
  logic [31:0] v;
  int          err_count = 0;
  int          n_tests   = 0;

  // 250 MHz system clock
  always #2 sys_clk_in = ~sys_clk_in;

  timer_irq_mode_control_slice i_timer_irq_mode_control_slice (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(write), .reg_read_in(read),
    .reg_rdata_out(rdata), .timer_ch2_request_in(req[0]),
    .timer_ch3_request_in(req[1]), .timer_ch4_request_in(req[2]),
    .cpu_ack_in(ack), .cpu_irq_out(cpu_irq), .cpu_level_out(lvl),
    .cpu_irq_num_out(num), .dma_req_out(dma), .irq_out(irq));

  timer_core_model i_timer_core_model (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .fire_in(fire),
    .ack_en_in(ack_en), .cpu_irq_in(cpu_irq), .req_out(req),
    .ack_out(ack));

  task give_verdict;
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask : chk

  // one-cycle strobes, changed right after the rising edge
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge sys_clk_in);
    write <= 1'b0;
  endtask : wr

  task rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    read <= 1'b1;
    @(posedge sys_clk_in);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task pulse(input logic [2:0] m);
    @(posedge sys_clk_in);
    fire <= m;
    @(posedge sys_clk_in);
    fire <= 3'h0;
  endtask : pulse

  // bounded wait: 0 dma pulse, 1 core request, 2 ack, 3 core request low
  task wait_sig(input int w);
    int  i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 20 && !hit; i++)
    begin
      @(posedge sys_clk_in);
      #1;
      hit = (w == 0) ? (dma !== 8'h00) : (w == 1) ? (cpu_irq === 1'b1) :
            (w == 2) ? (ack === 1'b1) : (cpu_irq === 1'b0);
    end
    if (!hit)
    begin
      err_count++;
      $display("Error at %0t: wait %0d timed out", $time, w);
      give_verdict();
    end
  endtask : wait_sig

  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(`MODE_CTRL_B_ADDR, v); chk(v, 32'h0000_0000, "mode reset");
    rd(`IRQ_STATUS_ADDR, v); chk(v, 32'h0000_0000, "status reset");
    rd(`IRQ_MASK_ADDR, v); chk(v, 32'h0000_0000, "mask reset");
    // active states 00, 01 and 10: no detection
    wr(`MODE_CTRL_B_ADDR, 32'h5333_1300);
    pulse(3'h7);
    repeat (6) @(posedge sys_clk_in);
    #1;
    chk(32'(cpu_irq), 32'h0, "no core request");
    rd(`IRQ_STATUS_ADDR, v); chk(v, 32'h0000_0000, "no status");
    wr(`MODE_CTRL_B_ADDR, 32'hFFFF_FFFF);
    rd(`MODE_CTRL_B_ADDR, v); chk(v, 32'h7777_7700, "fixed zeros");
    // 25 level 3, 26 level 5, 27 dma channel 4
    wr(`MODE_CTRL_B_ADDR, 32'h7465_6300);
    pulse(3'h7);
    wait_sig(0);
    chk(32'(dma), 32'h0000_0010, "dma channel 4");
    @(posedge sys_clk_in);
    #1;
    chk(32'(dma), 32'h0000_0000, "dma one pulse");
    wait_sig(1);
    chk(32'(lvl), 32'h0000_0005, "highest level");
    chk(32'(num), 32'h0000_001A, "number 26");
    wr(`IRQ_MASK_ADDR, 32'h0000_0007);
    #1;
    chk(32'(irq), 32'h0000_0001, "summary set");
    rd(`IRQ_STATUS_ADDR, v); chk(v, 32'h0000_0007, "all three events");
    @(posedge sys_clk_in);
    #1;
    chk(32'(irq), 32'h0000_0000, "summary cleared");
    ack_en <= 1'b1;
    wait_sig(2);
    @(posedge sys_clk_in);
    #1;
    chk(32'(cpu_irq), 32'h0000_0001, "next source shown");
    chk(32'(lvl), 32'h0000_0003, "level 3");
    chk(32'(num), 32'h0000_0019, "number 25");
    wait_sig(3);
    ack_en <= 1'b0;
    // every dma channel code; 26 at level 0 stays off the core
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(`MODE_CTRL_B_ADDR, {8'h70 | 8'(ch), 8'h60, 16'h0000});
      pulse(3'h4);
      wait_sig(0);
      chk(32'(dma), 32'h0000_0001 << ch, "dma channel code");
    end
    pulse(3'h2);
    repeat (6) @(posedge sys_clk_in);
    #1;
    chk(32'(cpu_irq), 32'h0000_0000, "level 0 disabled");
    rd(`IRQ_STATUS_ADDR, v); chk(v, 32'h0000_0006, "status only");
    wr(32'hFFFF_E200, 32'hFFFF_FFFF);
    rd(32'hFFFF_E200, v); chk(v, 32'h0000_0000, "unmapped");
    rd(`IRQ_MASK_ADDR, v); chk(v, 32'h0000_0007, "mask kept");
    // 27 at level 1 reaches the core as number 27
    wr(`MODE_CTRL_B_ADDR, 32'h6100_0000);
    pulse(3'h4);
    wait_sig(1);
    chk(32'(lvl), 32'h0000_0001, "level 1");
    chk(32'(num), 32'h0000_001B, "number 27");
    chk(32'(irq), 32'h0000_0001, "summary from 27");
    ack_en <= 1'b1;
    wait_sig(3);
    ack_en <= 1'b0;
    // reset in mid-run returns the registers to zero
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(`MODE_CTRL_B_ADDR, v);
    chk(v, 32'h0000_0000, "mode after reset");
    rd(`IRQ_STATUS_ADDR, v);
    chk(v, 32'h0000_0000, "status after reset");
    rd(`IRQ_MASK_ADDR, v);
    chk(v, 32'h0000_0000, "mask after reset");
    give_verdict();
  end
endmodule : tb
